//--- digital_input_event_mapper.sv
// Digital input event mapper: eight pins, polarity and function per pin, AXI4-Lite registers.
// Pins may be asynchronous to clock; process state inputs come from the sequencer.
// Operation
// RULE1: Per-input polarity selects active pin level
// RULE2: Polarity resets to active-low
// RULE3: Code 1 starts only when no layer runs
// RULE4: Code 3 ends deposit like final thickness
// RULE5: Code 4 samples rate monitor if enabled
// RULE6: Code 5 holds rate monitor while active
// RULE7: Code 6 suppresses crystal fail and stop
// RULE8: Code 8 holds soak phase while active
// RULE9: Soak hold parameter valid 1 to 10
// RULE10: Code 9 resets in ready or last idle
// RULE11: Codes 10-17 form eight-bit process ID
// RULE12: Code 18 switches crystal on named sensor
// RULE13: Code 19 holds power in non-deposit states
// RULE14: Code 20 refuses every layer start
// RULE15: Code 0 ignored, 2 stops, 7 zeroes
// RULE16: Sync, polarity, then edge or level decode
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "dio_map_consts.svh"

module digital_input_event_mapper
(
    input  wire logic                        clock,
    input  wire logic                        rst,
    input  wire logic [`NUM_INPUTS-1:0]      pins,
    input  wire logic                        layer_running,
    input  wire logic                        in_ready_state,
    input  wire logic                        in_last_idle,
    input  wire logic                        rate_monitor_enabled,
    input  wire logic                        in_soak,
    input  wire logic [3:0]                  soak_phase,
    input  wire logic                        crystal_fail_raw,
    input  wire logic [11:0]                 s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [11:0]                 s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    output logic                             start_pulse,
    output logic                             stop_pulse,
    output logic                             end_deposit_pulse,
    output logic                             rate_sample_pulse,
    output logic                             zero_thickness_pulse,
    output logic                             process_reset_pulse,
    output logic                             crystal_switch_pulse,
    output logic [3:0]                       crystal_switch_sensor,
    output logic                             rate_hold,
    output logic                             soak_hold,
    output logic                             nondeposit_hold,
    output logic                             start_inhibit,
    output logic                             crystal_fail_out,
    output logic                             crystal_fail_stop,
    output logic [7:0]                       process_id,
    output logic                             irq
);
    import dio_map_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and synchronisers

    logic [`NUM_INPUTS-1:0]   polarity_ff;
    func_code_type            func_ff  [`NUM_INPUTS];
    func_param_type           param_ff [`NUM_INPUTS];
    logic [`NUM_INPUTS-1:0]   sync1_ff;
    logic [`NUM_INPUTS-1:0]   sync2_ff;
    logic [`NUM_INPUTS-1:0]   act_ff;
    logic [`NUM_INPUTS-1:0]   act_prev_ff;
    logic [`ST_W-1:0]         status_ff;
    logic [`ST_W-1:0]         mask_ff;
    logic [`ST_W-1:0]         event_set;
    logic [`NUM_INPUTS-1:0]   rise;
    logic [7:0]               nxt_process_id;

    // Two stages keep metastability away from decoding
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sync1_ff    <= '0;
            sync2_ff    <= '0;
            act_ff      <= '0;
            act_prev_ff <= '0;
        end
        else
        begin
            sync1_ff    <= pins;                       // RULE16
            sync2_ff    <= sync1_ff;
            act_ff      <= sync2_ff ^ ~polarity_ff;    // RULE1
            act_prev_ff <= act_ff;
        end
    end

    assign rise = act_ff & ~act_prev_ff;               // RULE16

    function automatic logic any_level(input func_code_type code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < `NUM_INPUTS; i++)
            if (act_ff[i] && func_ff[i] == code)
                hit = 1'b1;
        return hit;
    endfunction

    function automatic logic any_edge(input func_code_type code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < `NUM_INPUTS; i++)
            if (rise[i] && func_ff[i] == code)
                hit = 1'b1;
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Function decode

    logic soak_match;
    logic switch_hit;
    logic [3:0] switch_sensor;

    always_comb
    begin
        soak_match    = 1'b0;
        switch_hit    = 1'b0;
        switch_sensor = 4'h0;
        nxt_process_id = process_id;
        for (int i = 0; i < `NUM_INPUTS; i++)
        begin
            if (act_ff[i] && func_ff[i] == `FC_SOAK_HOLD && in_soak
                && param_ff[i] >= `SOAK_MIN && param_ff[i] <= `SOAK_MAX
                && param_ff[i] == soak_phase)                            // RULE8 RULE9
                soak_match = 1'b1;
            if (rise[i] && func_ff[i] == `FC_XTAL_SWITCH && !switch_hit) // RULE12
            begin
                switch_hit    = 1'b1;
                switch_sensor = param_ff[i];
            end
            if (func_ff[i] >= `FC_SEL_FIRST && func_ff[i] <= `FC_SEL_LAST)  // RULE11
                nxt_process_id[3'(func_ff[i] - `FC_SEL_FIRST)] = act_ff[i];
        end
    end

    always_comb
    begin
        event_set = '0;
        event_set[`ST_START] = any_edge(`FC_START) && !layer_running
                               && !any_level(`FC_START_INHIBIT);            // RULE3 RULE14
        event_set[`ST_START_REFUSED] = any_edge(`FC_START) && !event_set[`ST_START];
        event_set[`ST_STOP]        = any_edge(`FC_STOP);                    // RULE15
        event_set[`ST_END_DEP]     = any_edge(`FC_END_DEP);                 // RULE4
        event_set[`ST_RATE_SAMPLE] = any_edge(`FC_RATE_SAMPLE)
                                     && rate_monitor_enabled;               // RULE5
        event_set[`ST_ZERO]        = any_edge(`FC_ZERO_THICK);              // RULE15
        event_set[`ST_RESET]       = any_edge(`FC_RESET)
                                     && (in_ready_state || in_last_idle);   // RULE10
        event_set[`ST_XTAL_SWITCH] = switch_hit;
        event_set[`ST_SEL_CHANGE]  = nxt_process_id != process_id;
    end

    // Outputs registered so the sequencer sees clean one-cycle events
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            start_pulse           <= 1'b0;
            stop_pulse            <= 1'b0;
            end_deposit_pulse     <= 1'b0;
            rate_sample_pulse     <= 1'b0;
            zero_thickness_pulse  <= 1'b0;
            process_reset_pulse   <= 1'b0;
            crystal_switch_pulse  <= 1'b0;
            crystal_switch_sensor <= 4'h0;
            rate_hold             <= 1'b0;
            soak_hold             <= 1'b0;
            nondeposit_hold       <= 1'b0;
            start_inhibit         <= 1'b0;
            crystal_fail_out      <= 1'b0;
            crystal_fail_stop     <= 1'b0;
            process_id            <= 8'h00;
        end
        else
        begin
            start_pulse          <= event_set[`ST_START];
            stop_pulse           <= event_set[`ST_STOP];
            end_deposit_pulse    <= event_set[`ST_END_DEP];
            rate_sample_pulse    <= event_set[`ST_RATE_SAMPLE];
            zero_thickness_pulse <= event_set[`ST_ZERO];
            process_reset_pulse  <= event_set[`ST_RESET];
            crystal_switch_pulse <= switch_hit;                          // RULE12
            if (switch_hit)
                crystal_switch_sensor <= switch_sensor;
            rate_hold        <= any_level(`FC_RATE_HOLD);                // RULE6
            soak_hold        <= soak_match;                              // RULE8
            nondeposit_hold  <= any_level(`FC_NONDEP_HOLD);              // RULE13
            start_inhibit    <= any_level(`FC_START_INHIBIT);            // RULE14
            crystal_fail_out <= crystal_fail_raw && !any_level(`FC_XTAL_INHIBIT);  // RULE7
            crystal_fail_stop <= crystal_fail_raw && !any_level(`FC_XTAL_INHIBIT); // RULE7
            process_id       <= nxt_process_id;                          // RULE11
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    wr_state_type   wr_state_ff;
    logic [11:0]    awaddr_ff;
    logic [31:0]    wdata_ff;
    logic           aw_have_ff;
    logic           w_have_ff;
    logic           wr_go;
    logic           wr_hit;
    logic [`ST_W-1:0] w1c;

    assign wr_go  = aw_have_ff && w_have_ff && wr_state_ff == AXI_IDLE;
    assign wr_hit = awaddr_ff[7:0] == `OFS_POLARITY || awaddr_ff[7:0] == `OFS_STATUS
                    || awaddr_ff[7:0] == `OFS_MASK
                    || (awaddr_ff[7:0] >= `OFS_FUNC_BASE && awaddr_ff[7:0] <= `OFS_FUNC_LAST
                        && awaddr_ff[1:0] == 2'b00);
    assign w1c = (wr_go && awaddr_ff[7:0] == `OFS_STATUS) ? wdata_ff[`ST_W-1:0] : '0;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            wr_state_ff   <= AXI_IDLE;
            aw_have_ff    <= 1'b0;
            w_have_ff     <= 1'b0;
            awaddr_ff     <= 12'h000;
            wdata_ff      <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_have_ff && !s_axi_awready && wr_state_ff == AXI_IDLE;
            s_axi_wready  <= !w_have_ff && !s_axi_wready && wr_state_ff == AXI_IDLE;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_ff <= 1'b1;
                awaddr_ff  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata;
            end
            case (wr_state_ff)
                AXI_IDLE:
                    if (wr_go)
                    begin
                        wr_state_ff  <= AXI_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
                    end
                AXI_RESP:
                    if (s_axi_bready)
                    begin
                        s_axi_bvalid <= 1'b0;
                        aw_have_ff   <= 1'b0;
                        w_have_ff    <= 1'b0;
                        wr_state_ff  <= AXI_IDLE;
                    end
                default:
                    wr_state_ff <= AXI_IDLE;
            endcase
        end
    end

    // Register writes; byte strobes are ignored, whole words are written
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            polarity_ff <= `POLARITY_RESET;                              // RULE2
            mask_ff     <= `MASK_RESET;
            for (int i = 0; i < `NUM_INPUTS; i++)
            begin
                func_ff[i]  <= `FC_NONE;                                 // RULE15
                param_ff[i] <= '0;
            end
        end
        else if (wr_go)
        begin
            if (awaddr_ff[7:0] == `OFS_POLARITY)
                polarity_ff <= wdata_ff[`NUM_INPUTS-1:0];
            if (awaddr_ff[7:0] == `OFS_MASK)
                mask_ff <= wdata_ff[`ST_W-1:0];
            for (int i = 0; i < `NUM_INPUTS; i++)
                if (awaddr_ff[7:0] == 8'(`OFS_FUNC_BASE + 4 * i))
                begin
                    func_ff[i]  <= wdata_ff[`FUNC_CODE_LSB +: `FUNC_W];
                    param_ff[i] <= wdata_ff[`FUNC_PARAM_LSB +: `PARAM_W];
                end
        end
    end

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            status_ff <= '0;
            irq       <= 1'b0;
        end
        else
        begin
            status_ff <= (status_ff & ~w1c) | event_set;
            irq       <= |(((status_ff & ~w1c) | event_set) & mask_ff);
        end
    end

    logic [31:0] rd_word;
    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (s_axi_araddr[7:0])
            `OFS_POLARITY:   rd_word[`NUM_INPUTS-1:0] = polarity_ff;
            `OFS_STATUS:     rd_word[`ST_W-1:0] = status_ff;
            `OFS_MASK:       rd_word[`ST_W-1:0] = mask_ff;
            `OFS_PIN_STATE:  rd_word[`NUM_INPUTS-1:0] = act_ff;
            `OFS_PROC_SEL:   rd_word[7:0] = process_id;
            `OFS_CTRL_STATE: rd_word[3:0] = {start_inhibit, nondeposit_hold, soak_hold, rate_hold};
            default:
                for (int i = 0; i < `NUM_INPUTS; i++)
                    if (s_axi_araddr[7:0] == 8'(`OFS_FUNC_BASE + 4 * i))
                    begin
                        rd_word[`FUNC_CODE_LSB +: `FUNC_W]   = func_ff[i];
                        rd_word[`FUNC_PARAM_LSB +: `PARAM_W] = param_ff[i];
                    end
        endcase
    end

    logic rd_hit;
    assign rd_hit = s_axi_araddr[7:0] <= `OFS_CTRL_STATE && s_axi_araddr[1:0] == 2'b00
                    || (s_axi_araddr[7:0] >= `OFS_FUNC_BASE
                        && s_axi_araddr[7:0] <= `OFS_FUNC_LAST && s_axi_araddr[1:0] == 2'b00);

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid)
            begin
                if (s_axi_rready)
                    s_axi_rvalid <= 1'b0;
            end
            else if (s_axi_arvalid && !s_axi_arready)
            begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

endmodule

//--- digital_input_event_mapper_assertions.sv
// Checker for the digital input event mapper: gating, pulse shape and reset.
// Assumes it is bound to the mapper and sees only its ports.
`timescale 1ns/1ps

module dio_map_checker
(
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       layer_running,
    input wire logic       in_ready_state,
    input wire logic       in_last_idle,
    input wire logic       rate_monitor_enabled,
    input wire logic       in_soak,
    input wire logic [3:0] soak_phase,
    input wire logic       crystal_fail_raw,
    input wire logic       start_pulse,
    input wire logic       rate_sample_pulse,
    input wire logic       process_reset_pulse,
    input wire logic       soak_hold,
    input wire logic       crystal_fail_out,
    input wire logic       crystal_fail_stop,
    input wire logic       irq,
    input wire logic [7:0] process_id
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    // Decode gates are sampled in the cycle before the registered event
    a_start_gated: assert property (start_pulse |-> !$past(layer_running))
        else $error("start issued while a layer ran");
    a_sample_gated: assert property (rate_sample_pulse |-> $past(rate_monitor_enabled))
        else $error("rate sample without feature enabled");
    a_reset_gated: assert property (
        process_reset_pulse |-> $past(in_ready_state || in_last_idle))
        else $error("process reset outside ready or last idle");
    a_soak_gated: assert property (
        soak_hold |-> $past(in_soak) && ($past(soak_phase) inside {[1:10]}))
        else $error("soak hold outside a valid soak");
    a_fail_cause: assert property (crystal_fail_out |-> $past(crystal_fail_raw))
        else $error("crystal fail output without cause");
    a_fail_pair: assert property (crystal_fail_out == crystal_fail_stop)
        else $error("crystal fail output and stop disagree");
    // Edge events need a full inactive spell, so one input never gives two pulses in a row
    a_pulse_single: assert property (start_pulse |=> !start_pulse)
        else $error("start pulse longer than one cycle");
    a_reset_clear: assert property ($past(rst) |-> !irq && process_id == 8'h00)
        else $error("outputs not cleared by reset");
    a_start_spaced: assert property (start_pulse |=> !start_pulse [*2])
        else $error("start pulses too close together");
endmodule

bind digital_input_event_mapper dio_map_checker chk_u (.*);

//--- digital_input_event_mapper_bench.sv
// Bench for the digital input event mapper over AXI4-Lite and pins.
// Assumes the mapper, its package, header, checker and pin model compiled first.
`timescale 1ns/1ps
`include "dio_map_consts.svh"

module digital_input_event_mapper_bench;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        slow = 1'b0;
    logic [7:0]  want = 8'h00;
    logic [7:0]  pins;
    logic        layer_running = 1'b0, in_ready_state = 1'b1, in_last_idle = 1'b0;
    logic        rate_monitor_enabled = 1'b1, in_soak = 1'b1, crystal_fail_raw = 1'b1;
    logic [3:0]  soak_phase = 4'h2;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf, crystal_switch_sensor;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        start_pulse, stop_pulse, end_deposit_pulse, rate_sample_pulse;
    logic        zero_thickness_pulse, process_reset_pulse, crystal_switch_pulse;
    logic        rate_hold, soak_hold, nondeposit_hold, start_inhibit, irq;
    logic        crystal_fail_out, crystal_fail_stop;
    logic [7:0]  process_id;
    logic [6:0]  pv;
    logic [4:0]  lv;
    int          pc[7];
    int          error_cnt = 0;
    int          tests_run = 0;
    ////////////////////////////////////////////////////////////////////////////////
    always #4 clock = ~clock;
    assign pv = {crystal_switch_pulse, process_reset_pulse, zero_thickness_pulse,
                 rate_sample_pulse, end_deposit_pulse, stop_pulse, start_pulse};
    assign lv = {nondeposit_hold, soak_hold, crystal_fail_stop, crystal_fail_out, rate_hold};
    // Pulses last one cycle, so count them at every edge
    always @(posedge clock)
        for (int j = 0; j < 7; j++)
            if (pv[j] === 1'b1)
                pc[j]++;

    pin_equipment equip_u (.clock(clock), .want(want), .slow(slow), .pins(pins));

    // Every mapper port is driven or watched by a bench signal of the same name
    digital_input_event_mapper dut_u (.*);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, s, e);
        end
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        chk(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
    endtask

    task automatic setfn(input int i, input logic [4:0] c, input logic [3:0] p);
        axi_wr(`OFS_FUNC_BASE + 12'(4 * i), {20'h0, p, 3'h0, c}, `RESP_OKAY);
    endtask

    task automatic setpin(input int i, input logic v);
        want[i] <= v;
        repeat (10) @(posedge clock);
    endtask

    // Edge function on input i, x is the pulse expected (-1 for none)
    task automatic fire(input int i, input logic [4:0] c, input logic [3:0] p, input int x);
        setfn(i, c, p);
        foreach (pc[j]) pc[j] = 0;
        setpin(i, 1'b1);
        setpin(i, 1'b0);
        for (int j = 0; j < 7; j++)
            chk(pc[j], 32'(j == x));
    endtask

    task automatic lvl(input logic [4:0] c, input logic [3:0] p, input logic [4:0] e);
        setfn(2, c, p);
        setpin(2, 1'b1);
        chk(lv, e);
        setpin(2, 1'b0);
        chk(lv, 5'b00110);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #100000;
        error_cnt++;
        complete_run();
    end

    initial
    begin
        logic [4:0] codes[8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h07, 5'h09, 5'h12};
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        axi_rd(`OFS_POLARITY, 32'h0, `RESP_OKAY);
        axi_rd(`OFS_MASK, 32'h0, `RESP_OKAY);
        axi_rd(`OFS_FUNC_BASE, 32'h0, `RESP_OKAY);
        axi_rd(12'h040, 32'h0, `RESP_SLVERR);
        axi_wr(`OFS_PIN_STATE, 32'hff, `RESP_SLVERR);
        $display("reset test done");
        axi_wr(`OFS_POLARITY, 32'hff, `RESP_OKAY);
        for (int k = 0; k < 8; k++)
            fire(0, codes[k], 4'h5, k - 1);
        chk(crystal_switch_sensor, 4'h5);
        layer_running <= 1'b1;
        fire(0, 5'h01, 4'h0, -1);
        axi_rd(`OFS_STATUS, 32'h0ff, `RESP_OKAY);
        axi_wr(`OFS_STATUS, 32'h1ff, `RESP_OKAY);
        axi_rd(`OFS_STATUS, 32'h0, `RESP_OKAY);
        layer_running <= 1'b0;
        rate_monitor_enabled <= 1'b0;
        in_ready_state <= 1'b0;
        fire(0, 5'h04, 4'h0, -1);
        fire(0, 5'h09, 4'h0, -1);
        in_last_idle <= 1'b1;
        fire(0, 5'h09, 4'h0, 5);
        setfn(1, 5'h14, 4'h0);
        setpin(1, 1'b1);
        chk(start_inhibit, 1'b1);
        fire(0, 5'h01, 4'h0, -1);
        setpin(1, 1'b0);
        $display("edge test done");
        lvl(5'h05, 4'h2, 5'b00111);
        lvl(5'h06, 4'h2, 5'b00000);
        lvl(5'h08, 4'h2, 5'b01110);
        lvl(5'h13, 4'h2, 5'b10110);
        soak_phase <= 4'hb;
        lvl(5'h08, 4'hb, 5'b00110);
        soak_phase <= 4'ha;
        lvl(5'h08, 4'ha, 5'b01110);
        $display("level test done");
        axi_wr(`OFS_POLARITY, 32'hfb, `RESP_OKAY);
        setfn(2, 5'h05, 4'h0);
        setpin(2, 1'b0);
        chk(rate_hold, 1'b1);
        setpin(2, 1'b1);
        chk(rate_hold, 1'b0);
        setpin(2, 1'b0);
        axi_wr(`OFS_POLARITY, 32'hff, `RESP_OKAY);
        $display("polarity test done");
        slow <= 1'b1;
        for (int i = 0; i < 8; i++)
            setfn(i, 5'(10 + i), 4'h0);
        axi_wr(`OFS_STATUS, 32'h1ff, `RESP_OKAY);
        axi_wr(`OFS_MASK, 32'h100, `RESP_OKAY);
        setpin(0, 1'b1);
        want <= 8'ha5;
        repeat (10) @(posedge clock);
        chk(process_id, 8'ha5);
        chk(irq, 1'b1);
        axi_wr(`OFS_STATUS, 32'h100, `RESP_OKAY);
        repeat (4) @(posedge clock);
        chk(irq, 1'b0);
        axi_wr(`OFS_MASK, 32'h0, `RESP_OKAY);
        want <= 8'h00;
        repeat (10) @(posedge clock);
        chk(irq, 1'b0);
        chk(process_id, 8'h00);
        axi_rd(`OFS_STATUS, 32'h100, `RESP_OKAY);
        $display("selection test done");
        complete_run();
    end
endmodule

//--- dio_map_consts.svh
// Register map, field layout and reset values of the digital input event mapper.
// Included by the mapper package and the mapper module.
`ifndef DIO_MAP_CONSTS_SVH
`define DIO_MAP_CONSTS_SVH

`define NUM_INPUTS        8
`define FUNC_W            5
`define PARAM_W           4
// Register byte offsets
`define OFS_POLARITY      8'h00
`define OFS_STATUS        8'h04
`define OFS_MASK          8'h08
`define OFS_PIN_STATE     8'h0c
`define OFS_PROC_SEL      8'h10
`define OFS_CTRL_STATE    8'h14
`define OFS_FUNC_BASE     8'h20
`define OFS_FUNC_LAST     8'h3c
// Function word fields
`define FUNC_CODE_LSB     0
`define FUNC_PARAM_LSB    8
// Reset values and soak parameter limits
`define POLARITY_RESET    8'h00
`define MASK_RESET        9'h000
`define SOAK_MIN          4'h1
`define SOAK_MAX          4'ha
// Function codes
`define FC_NONE           5'h00
`define FC_START          5'h01
`define FC_STOP           5'h02
`define FC_END_DEP        5'h03
`define FC_RATE_SAMPLE    5'h04
`define FC_RATE_HOLD      5'h05
`define FC_XTAL_INHIBIT   5'h06
`define FC_ZERO_THICK     5'h07
`define FC_SOAK_HOLD      5'h08
`define FC_RESET          5'h09
`define FC_SEL_FIRST      5'h0a
`define FC_SEL_LAST       5'h11
`define FC_XTAL_SWITCH    5'h12
`define FC_NONDEP_HOLD    5'h13
`define FC_START_INHIBIT  5'h14
// Status bit positions
`define ST_START          0
`define ST_STOP           1
`define ST_END_DEP        2
`define ST_RATE_SAMPLE    3
`define ST_ZERO           4
`define ST_RESET          5
`define ST_XTAL_SWITCH    6
`define ST_START_REFUSED  7
`define ST_SEL_CHANGE     8
`define ST_W              9
// AXI responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

//--- dio_map_pkg.sv
// Types shared by the digital input event mapper.
// Assumes dio_map_consts.svh is on the include path.
`include "dio_map_consts.svh"

package dio_map_pkg;
    typedef logic [`FUNC_W-1:0]  func_code_type;
    typedef logic [`PARAM_W-1:0] func_param_type;
    typedef enum logic [1:0] {AXI_IDLE, AXI_RESP} wr_state_type;
endpackage

//--- pin_equipment.sv
// External equipment model driving the eight rear-panel input pins.
// Assumes the bench sets the wanted levels; slow mode adds contact delay.
`timescale 1ns/1ps

module pin_equipment
(
    input  wire logic       clock,
    input  wire logic [7:0] want,
    input  wire logic       slow,
    output logic [7:0]      pins = 8'h00
);
    logic [7:0] d1_ff = 8'h00;
    logic [7:0] d2_ff = 8'h00;
    ////////////////////////////////////////////////////////////////////////////////
    // Slow contacts settle two cycles late, like relay closures
    always @(posedge clock)
    begin
        d1_ff <= want;
        d2_ff <= d1_ff;
        pins  <= slow ? d2_ff : want;
    end
endmodule
